// *** pwrc_cfg.svh ***
// Offsets, field positions, reset values and counts of the power control.
`ifndef PWRC_CFG_SVH
`define PWRC_CFG_SVH

`define PWRC_AW          8
`define PWRC_ADDR_PWR    8'h00
`define PWRC_ADDR_GATE   8'h04
// Both internal oscillators start enabled and the crystal starts disabled.
`define PWRC_PWR_RST     32'h0000_000c
`define PWRC_GATE_RST    32'h0000_0005
`define PWRC_PWR_WMASK   32'h00f3_0e0e
`define PWRC_GATE_WMASK  32'h0000_0007
`define PWRC_F_RDBK_LO   28
`define PWRC_F_POR       26
`define PWRC_F_TMRF      25
`define PWRC_F_PINF      24
`define PWRC_F_SEL_LO    20
`define PWRC_F_OSCOFF    17
`define PWRC_F_PINDIS    16
`define PWRC_F_DPD       11
`define PWRC_F_SPD       10
`define PWRC_F_SLOW      3
`define PWRC_F_FAST      2
`define PWRC_F_XTAL      1
`define PWRC_F_FLASH     2
`define PWRC_F_DMA       1
`define PWRC_F_CPU       0
`define PWRC_CNT_W       11
`define PWRC_DLY_BASE    11'd128
`define PWRC_RESP_OKAY   2'b00
`define PWRC_RESP_SLVERR 2'b10

`endif

// *** pwrc_pkg.sv ***
// Types and shared helpers of the power control block.
`include "pwrc_cfg.svh"
package pwrc_pkg;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_DEEP = 3'b010,
    ST_STBY = 3'b100
  } pwrc_mode_type;

  typedef struct packed {
    logic                  en;
    logic [`PWRC_AW-1:0]   addr;
    logic [31:0]           data;
    logic [3:0]            strb;
  } pwrc_wreq_type;

  function automatic logic pwrc_hit(input logic [`PWRC_AW-1:0] a);
    pwrc_hit = (a == `PWRC_ADDR_PWR) || (a == `PWRC_ADDR_GATE);
  endfunction : pwrc_hit

  // Byte-lane merge limited to the bits that software may change.
  function automatic logic [31:0] pwrc_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb,
                                             input logic [31:0] msk);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & msk;
    pwrc_merge = (old & ~m) | (wd & m);
  endfunction : pwrc_merge

endpackage : pwrc_pkg

// *** pwrc_axil.sv ***
// AXI4-Lite slave front end of the power control block.
`timescale 1ns/1ps
`include "pwrc_cfg.svh"
module pwrc_axil
  import pwrc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [`PWRC_AW-1:0] awaddr,
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  output logic                     bvalid,
  input  wire logic                bready,
  output logic [1:0]               bresp,
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [`PWRC_AW-1:0] araddr,
  output logic                     rvalid,
  input  wire logic                rready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output pwrc_wreq_type            wreq,
  input  wire logic [31:0]         rd_data
);

  typedef struct packed {
    logic                aw_got;
    logic                w_got;
    logic [`PWRC_AW-1:0] addr;
    logic [31:0]         data;
    logic [3:0]          strb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } pwrc_axs_type;

  pwrc_axs_type s_r;
  pwrc_axs_type s_nxt;

  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready  = !s_r.w_got && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign rvalid  = s_r.rvalid;
  assign rdata   = s_r.rdata;
  assign rresp   = s_r.rresp;
  assign wreq    = '{en: s_r.aw_got && s_r.w_got && !s_r.bvalid,
                     addr: s_r.addr, data: s_r.data, strb: s_r.strb};

  always_comb
  begin
    s_nxt = s_r;
    if (awvalid && awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.addr   = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.data  = wdata;
      s_nxt.strb  = wstrb;
    end
    if (wreq.en)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = pwrc_hit(s_r.addr) ? `PWRC_RESP_OKAY
                                        : `PWRC_RESP_SLVERR;
    end
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_data;
      s_nxt.rresp  = pwrc_hit(araddr) ? `PWRC_RESP_OKAY
                                      : `PWRC_RESP_SLVERR;
    end
    if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  chk_bresp_held: assert property (@(posedge clk) disable iff (reset)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");

endmodule : pwrc_axil

// *** pwrc_wtmr.sv ***
// Deep power-down wake timer counting slow oscillator periods.
`timescale 1ns/1ps
`include "pwrc_cfg.svh"
module pwrc_wtmr
  import pwrc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic       osc_on,
  input  wire logic [3:0] sel,
  input  wire logic       slow_clk,
  output logic            expired
);

  typedef struct packed {
    logic                   s1;
    logic                   s2;
    logic                   s3;
    logic                   lvl;
    logic                   run;
    logic                   exp;
    logic [`PWRC_CNT_W-1:0] cnt;
    logic [`PWRC_CNT_W-1:0] target;
  } pwrc_tmr_type;

  pwrc_tmr_type s_r;
  pwrc_tmr_type s_nxt;
  logic         tick;

  // The lowest armed bit gives the shortest delay, so it wakes first.
  function automatic logic [`PWRC_CNT_W-1:0] dly(input logic [3:0] v);
    dly = '0;
    for (int i = 3; i >= 0; i--)
      if (v[i])
        dly = `PWRC_DLY_BASE << i;
  endfunction : dly

  assign expired = s_r.exp;

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.exp = 1'b0;
    s_nxt.s1  = slow_clk;
    s_nxt.s2  = s_r.s1;
    s_nxt.s3  = s_r.s2;
    tick      = (s_r.s2 == s_r.s3) && s_r.s3 && !s_r.lvl;
    if (s_r.s2 == s_r.s3)
      s_nxt.lvl = s_r.s3;
    if (start)
    begin
      s_nxt.cnt    = '0;
      s_nxt.target = dly(sel);
      // no timer wake with oscillator off
      s_nxt.run    = osc_on && (sel != 4'h0);
    end
    else if (stop)
      s_nxt.run = 1'b0;
    else if (s_r.run && tick)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_nxt.cnt == s_r.target)
      begin
        s_nxt.exp = 1'b1;
        s_nxt.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // expiry only at the armed count
  chk_expiry_count: assert property (@(posedge clk) disable iff (reset)
    $rose(s_r.exp) |-> s_r.cnt == s_r.target && s_r.target != '0)
    else $error("wake timer expired at the wrong count");

endmodule : pwrc_wtmr

// *** pwrc_top.sv ***
// Power control and bus-master clock gating with AXI4-Lite access.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "pwrc_cfg.svh"
module pwrc_top
  import pwrc_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [`PWRC_AW-1:0] AWADDR,
  input  wire logic [2:0]          AWPROT,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [`PWRC_AW-1:0] ARADDR,
  input  wire logic [2:0]          ARPROT,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  input  wire logic                UNLOCKED,
  input  wire logic                CPU_SLEEP_REQ,
  input  wire logic                DEBUG_ACTIVE,
  input  wire logic                STANDBY_WAKE,
  input  wire logic                WAKE_PIN_N,
  input  wire logic                SLOW_OSC_CLK,
  output logic                     DEEP_PD,
  output logic                     STANDBY_PD,
  output logic                     CPU_RESTART,
  output logic                     SLOW_OSC_EN,
  output logic                     FAST_OSC_EN,
  output logic                     XTAL_EN,
  output logic                     FLASH_PROG_CLK_EN,
  output logic                     DMA_CLK_EN,
  output logic                     CPU_CLK_EN
);

  // ******************************************************************
  // State
  // ******************************************************************

  typedef struct packed {
    pwrc_mode_type mode;
    logic [31:0]   pwr;
    logic [31:0]   gate;
    logic [3:0]    rdbk;
    logic          por_f;
    logic          tmr_f;
    logic          pin_f;
    logic          restart;
    logic          p1;
    logic          p2;
    logic          p3;
    logic          plvl;
    logic          outs_dpd;
  } pwrc_top_type;

  localparam pwrc_top_type RST_S = '{
    mode: ST_RUN, pwr: `PWRC_PWR_RST, gate: `PWRC_GATE_RST,
    rdbk: 4'h0, por_f: 1'b1, tmr_f: 1'b0, pin_f: 1'b0,
    restart: 1'b0, p1: 1'b1, p2: 1'b1, p3: 1'b1, plvl: 1'b1,
    outs_dpd: 1'b0};

  pwrc_top_type  s_r;
  pwrc_top_type  s_nxt;
  pwrc_wreq_type wreq;
  logic [31:0]   rd_data;
  logic          enter_dpd;
  logic          wake;
  logic          pin_fall;
  logic          tmr_exp;
  logic [3:0]    sel;

  assign sel = s_r.pwr[`PWRC_F_SEL_LO +: 4];

  // ******************************************************************
  // Bus and wake timer
  // ******************************************************************

  pwrc_axil pwrc_axil_inst (
    .clk     (CLK),
    .reset   (RESET),
    .awvalid (AWVALID),
    .awready (AWREADY),
    .awaddr  (AWADDR),
    .wvalid  (WVALID),
    .wready  (WREADY),
    .wdata   (WDATA),
    .wstrb   (WSTRB),
    .bvalid  (BVALID),
    .bready  (BREADY),
    .bresp   (BRESP),
    .arvalid (ARVALID),
    .arready (ARREADY),
    .araddr  (ARADDR),
    .rvalid  (RVALID),
    .rready  (RREADY),
    .rdata   (RDATA),
    .rresp   (RRESP),
    .wreq    (wreq),
    .rd_data (rd_data)
  );

  // The timer is told to stop on any wake so a late expiry cannot
  // be taken for the cause of a later deep power-down. It also stops
  // once the slow oscillator is set to go off, so no timer wake can follow.
  pwrc_wtmr pwrc_wtmr_inst (
    .clk      (CLK),
    .reset    (RESET),
    .start    (enter_dpd),
    .stop     (wake || s_r.pwr[`PWRC_F_OSCOFF]),
    .osc_on   (!s_r.pwr[`PWRC_F_OSCOFF]),
    .sel      (sel),
    .slow_clk (SLOW_OSC_CLK),
    .expired  (tmr_exp)
  );

  // ******************************************************************
  // Read path
  // ******************************************************************

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (ARADDR == `PWRC_ADDR_PWR)
    begin
      rd_data = s_r.pwr;
      rd_data[`PWRC_F_RDBK_LO +: 4] = s_r.rdbk;
      rd_data[`PWRC_F_POR] = s_r.por_f;
      rd_data[`PWRC_F_TMRF] = s_r.tmr_f;
      rd_data[`PWRC_F_PINF] = s_r.pin_f;
    end
    else if (ARADDR == `PWRC_ADDR_GATE)
      rd_data = s_r.gate;
  end

  // ******************************************************************
  // Next state
  // ******************************************************************

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.restart = 1'b0;
    enter_dpd     = 1'b0;
    wake          = 1'b0;
    // Only the second and third stages are compared, so a metastable
    // first stage never reaches the edge detector.
    s_nxt.p1 = WAKE_PIN_N;
    s_nxt.p2 = s_r.p1;
    s_nxt.p3 = s_r.p2;
    if (s_r.p2 == s_r.p3)
      s_nxt.plvl = s_r.p3;
    pin_fall = (s_r.p2 == s_r.p3) && !s_r.p3 && s_r.plvl;

    if (wreq.en && UNLOCKED)
    begin
      if (wreq.addr == `PWRC_ADDR_PWR)
        s_nxt.pwr = pwrc_merge(s_r.pwr, wreq.data, wreq.strb,
                               `PWRC_PWR_WMASK);
      else if (wreq.addr == `PWRC_ADDR_GATE)
        s_nxt.gate = pwrc_merge(s_r.gate, wreq.data, wreq.strb,
                                `PWRC_GATE_WMASK);
    end

    unique case (s_r.mode)
      ST_RUN:
      begin
        if (CPU_SLEEP_REQ && !DEBUG_ACTIVE)
        begin
          if (s_r.pwr[`PWRC_F_DPD])
          begin
            enter_dpd  = 1'b1;
            s_nxt.mode = ST_DEEP;
            s_nxt.rdbk = sel;
            s_nxt.por_f = 1'b0;
            s_nxt.tmr_f = 1'b0;
            s_nxt.pin_f = 1'b0;
          end
          else if (s_r.pwr[`PWRC_F_SPD])
            s_nxt.mode = ST_STBY;
        end
      end
      ST_DEEP:
      begin
        if (pin_fall && !s_r.pwr[`PWRC_F_PINDIS])
        begin
          s_nxt.pin_f = 1'b1;
          wake        = 1'b1;
        end
        if (tmr_exp)
        begin
          s_nxt.tmr_f = 1'b1;
          wake        = 1'b1;
        end
      end
      ST_STBY:
      begin
        if (STANDBY_WAKE)
          wake = 1'b1;
      end
    endcase

    if (wake)
    begin
      s_nxt.mode                = ST_RUN;
      s_nxt.restart             = 1'b1;
      s_nxt.pwr[`PWRC_F_DPD]    = 1'b0;
      s_nxt.pwr[`PWRC_F_SPD]    = 1'b0;
    end
    s_nxt.outs_dpd = (s_nxt.mode == ST_DEEP);
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      s_r <= RST_S;
    else
      s_r <= s_nxt;
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************

  assign DEEP_PD     = s_r.outs_dpd;
  assign STANDBY_PD  = (s_r.mode == ST_STBY);
  assign CPU_RESTART = s_r.restart;
  assign SLOW_OSC_EN = s_r.pwr[`PWRC_F_SLOW] &&
                       !(s_r.outs_dpd && s_r.pwr[`PWRC_F_OSCOFF]);
  assign FAST_OSC_EN = s_r.pwr[`PWRC_F_FAST];
  assign XTAL_EN     = s_r.pwr[`PWRC_F_XTAL];
  assign FLASH_PROG_CLK_EN = s_r.gate[`PWRC_F_FLASH];
  assign DMA_CLK_EN  = s_r.gate[`PWRC_F_DMA];
  assign CPU_CLK_EN  = s_r.gate[`PWRC_F_CPU];

  // ******************************************************************
  // Checks
  // ******************************************************************

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_locked_write_kept: assert property (
    wreq.en && !UNLOCKED && !wake |=> $stable(s_r.gate) && $stable(s_r.pwr))
    else $error("locked write changed a protected register");

  chk_deep_entry: assert property (
    s_r.mode == ST_RUN && CPU_SLEEP_REQ && !DEBUG_ACTIVE &&
      s_r.pwr[`PWRC_F_DPD] |=> DEEP_PD && !STANDBY_PD)
    else $error("deep power-down not entered");

  // no timer wake with oscillator off
  chk_osc_off_no_timer: assert property (
    s_r.pwr[`PWRC_F_OSCOFF] && $past(s_r.pwr[`PWRC_F_OSCOFF])
      |-> !tmr_exp)
    else $error("timer wake with the slow oscillator off");

  chk_debug_refuses_dpd: assert property (
    s_r.mode == ST_RUN && DEBUG_ACTIVE |=> !DEEP_PD)
    else $error("deep power-down entered with debug active");

  chk_entry_clears_flags: assert property (
    $rose(DEEP_PD) |-> !s_r.por_f && !s_r.tmr_f && !s_r.pin_f)
    else $error("wake flags not cleared on deep entry");

  chk_readback_loaded: assert property (
    enter_dpd |=> s_r.rdbk == $past(sel) && DEEP_PD)
    else $error("timer readback not loaded on deep entry");

  chk_pin_wake_flag: assert property (
    DEEP_PD && pin_fall && !s_r.pwr[`PWRC_F_PINDIS]
      |=> s_r.pin_f && CPU_RESTART && !DEEP_PD)
    else $error("pin wake not taken");

  chk_pin_disabled: assert property (
    DEEP_PD && s_r.pwr[`PWRC_F_PINDIS] && !tmr_exp |=> DEEP_PD)
    else $error("disabled wake pin woke the device");

  chk_standby_entry: assert property (
    s_r.mode == ST_RUN && CPU_SLEEP_REQ && !DEBUG_ACTIVE &&
      !s_r.pwr[`PWRC_F_DPD] && s_r.pwr[`PWRC_F_SPD] |=> STANDBY_PD)
    else $error("standby power-down not entered");

  chk_restart_on_wake: assert property (
    $fell(DEEP_PD) || $fell(STANDBY_PD) |-> CPU_RESTART ##1 !CPU_RESTART)
    else $error("wake without a single restart pulse");

endmodule : pwrc_top

// *** tb_pwrc_top.sv ***
// Self-checking testbench of the power control block.
`timescale 1ns/1ps
`include "pwrc_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_pwrc_top
  import pwrc_pkg::*;
;
  logic        clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, unlocked, cpu_sleep_req;
  logic        debug_active, standby_wake, wake_pin_n, slow_clk, deep_pd;
  logic        standby_pd, cpu_restart, slow_osc_en, fast_osc_en, xtal_en;
  logic        flash_en, dma_en, cpu_clk_en;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [33:0] exp_q[$];
  logic [33:0] exp_v;
  int          error_cnt, cmp_count, slow_cnt, i;
  bit          slow_run;
  integer      seed = 32'h775faf83;

  pwrc_top pwrc_top_inst (
    .CLK               (clk),
    .RESET             (reset),
    .AWVALID           (awvalid),
    .AWREADY           (awready),
    .AWADDR            (awaddr),
    .AWPROT            (3'h0),
    .WVALID            (wvalid),
    .WREADY            (wready),
    .WDATA             (wdata),
    .WSTRB             (wstrb),
    .BVALID            (bvalid),
    .BREADY            (bready),
    .BRESP             (bresp),
    .ARVALID           (arvalid),
    .ARREADY           (arready),
    .ARADDR            (araddr),
    .ARPROT            (3'h0),
    .RVALID            (rvalid),
    .RREADY            (rready),
    .RDATA             (rdata),
    .RRESP             (rresp),
    .UNLOCKED          (unlocked),
    .CPU_SLEEP_REQ     (cpu_sleep_req),
    .DEBUG_ACTIVE      (debug_active),
    .STANDBY_WAKE      (standby_wake),
    .WAKE_PIN_N        (wake_pin_n),
    .SLOW_OSC_CLK      (slow_clk),
    .DEEP_PD           (deep_pd),
    .STANDBY_PD        (standby_pd),
    .CPU_RESTART       (cpu_restart),
    .SLOW_OSC_EN       (slow_osc_en),
    .FAST_OSC_EN       (fast_osc_en),
    .XTAL_EN           (xtal_en),
    .FLASH_PROG_CLK_EN (flash_en),
    .DMA_CLK_EN        (dma_en),
    .CPU_CLK_EN        (cpu_clk_en)
  );

  // ****************************************************************
  // Clocks and the checking side
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The slow clock rises every 16 cycles, far above the synchroniser delay.
  initial
  begin
    slow_clk = 1'b0;
    forever
    begin
      repeat (8) @(posedge clk);
      if (slow_run)
      begin
        slow_clk <= ~slow_clk;
        if (!slow_clk) slow_cnt++;
      end
    end
  end

  always @(posedge clk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      `CHK(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_v)
    end
  end

  // ****************************************************************
  // Bus and sequencing tasks
  // ****************************************************************
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic timed_out;
    error_cnt++;
    report_and_stop();
  endtask : timed_out

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] rsp, input logic [3:0] s = 4'hf);
    int n;
    exp_q.push_back({rsp, 32'h0});
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) timed_out();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) timed_out();
  endtask : rd

  task automatic sleep_req(input logic dbg);
    @(posedge clk);
    cpu_sleep_req <= 1'b1;
    debug_active  <= dbg;
    @(posedge clk);
    cpu_sleep_req <= 1'b0;
    debug_active  <= 1'b0;
    @(posedge clk);
  endtask : sleep_req

  task automatic wait_restart;
    int n;
    for (n = 0; n < 5000; n++)
    begin
      @(posedge clk);
      if (cpu_restart) break;
    end
    if (n == 5000) timed_out();
  endtask : wait_restart

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, unlocked} = '0;
    {cpu_sleep_req, debug_active, standby_wake, slow_run} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    wake_pin_n = 1'b1;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    `CHK({slow_osc_en, fast_osc_en, xtal_en}, 3'b110)
    `CHK({flash_en, dma_en, cpu_clk_en}, 3'b101)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h0400_000c});
    rd(`PWRC_ADDR_GATE, {`PWRC_RESP_OKAY, 32'h0000_0005});
    wr(`PWRC_ADDR_GATE, 32'h0000_0000, `PWRC_RESP_OKAY);
    rd(`PWRC_ADDR_GATE, {`PWRC_RESP_OKAY, 32'h0000_0005});
    unlocked <= 1'b1;
    wr(8'h08, 32'hffff_ffff, `PWRC_RESP_SLVERR);
    rd(8'h08, {`PWRC_RESP_SLVERR, 32'h0});
    // The processor clock bit is kept set, as software must.
    for (i = 0; i < 4; i++)
    begin
      r = $random(seed) | 32'h1;
      wr(`PWRC_ADDR_GATE, r, `PWRC_RESP_OKAY);
      rd(`PWRC_ADDR_GATE, {`PWRC_RESP_OKAY, 29'h0, r[2:0]});
      `CHK({flash_en, dma_en, cpu_clk_en}, r[2:0])
    end
    for (i = 0; i < 8; i++)
    begin
      wr(`PWRC_ADDR_PWR, {28'h0, i[2:0], 1'b0}, `PWRC_RESP_OKAY);
      `CHK({slow_osc_en, fast_osc_en, xtal_en}, i[2:0])
    end
    wr(`PWRC_ADDR_PWR, 32'h0000_040e, `PWRC_RESP_OKAY);
    sleep_req(1'b0);
    `CHK({standby_pd, deep_pd}, 2'b10)
    standby_wake <= 1'b1;
    wait_restart();
    standby_wake <= 1'b0;
    `CHK(standby_pd, 1'b0)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h0400_000e});
    wr(`PWRC_ADDR_PWR, 32'h0010_080c, `PWRC_RESP_OKAY);
    sleep_req(1'b1);
    `CHK(deep_pd, 1'b0)
    sleep_req(1'b0);
    `CHK(deep_pd, 1'b1)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h1010_080c});
    wake_pin_n <= 1'b0;
    wait_restart();
    wake_pin_n <= 1'b1;
    `CHK(deep_pd, 1'b0)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h1110_000c});
    // Two select bits armed, the pin disabled and pulled low meanwhile.
    wr(`PWRC_ADDR_PWR, 32'h0031_080c, `PWRC_RESP_OKAY);
    sleep_req(1'b0);
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h3031_080c});
    wake_pin_n <= 1'b0;
    slow_cnt = 0;
    slow_run <= 1'b1;
    wait_restart();
    slow_run <= 1'b0;
    wake_pin_n <= 1'b1;
    `CHK(slow_cnt, 128)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h3231_000c});
    wr(`PWRC_ADDR_PWR, 32'h0012_080c, `PWRC_RESP_OKAY);
    sleep_req(1'b0);
    `CHK(slow_osc_en, 1'b0)
    slow_run <= 1'b1;
    repeat (2300) @(posedge clk);
    slow_run <= 1'b0;
    `CHK(deep_pd, 1'b1)
    wake_pin_n <= 1'b0;
    wait_restart();
    wake_pin_n <= 1'b1;
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h1112_000c});
    // Only the low byte lane is enabled, so the upper fields must hold.
    wr(`PWRC_ADDR_PWR, 32'hffff_f1ff, `PWRC_RESP_OKAY, 4'h1);
    `CHK(xtal_en, 1'b1)
    rd(`PWRC_ADDR_PWR, {`PWRC_RESP_OKAY, 32'h1112_000e});
    report_and_stop();
  end
endmodule : tb_pwrc_top
